/* logic/asbd_decoder.sv */
// System bus decoder: slave selects and decoder transfer response
//
// Behaviour
// [R1] Master launches address/control from rising edge
// [R2] Address-only cycles never produce select or error
// [R3] Master holds address before sequential after address-only
// [R4] Master drives address lines only while granted
// [R5] New owner starts with an address-only transfer
// [R6] Granted master drives both phases, stops on loss
// [R7] One select per slave, at most one active
// [R8] Selects change only after response with wait low
// [R9] Decode-cycle option fixed at build time
// [R10] Decode wait inserted on nonsequential, never sequential
// [R11] Nonsequential select given at end of decode cycle
// [R12] Sequential select uses previously captured address
// [R13] Without decode cycles, live address decoded directly
// [R14] Decoder answers whenever no slave is selected
// [R15] Wait high extends; success from last and error
// [R16] Error for unmapped, protection or failed access
// [R17] After last response, next transfer treated nonsequential
// [R18] Retract: wait-last-error high, then last-error high
// [R19] Response code table; codes 101 and 110 unused
// [R20] A response is driven in every bus cycle
// [R21] Decoder answers address-only, decode, unmapped, illegal
// [R22] Retract support optional for bounded slaves
// [R23] Transfer type 00 idle, 10 nonseq, 11 seq
// [R24] Reset drops all selects, decoder answers done
// [R25] Unselected or resetting slaves float their response
// [R26] Map, protection and decode option are parameters
`timescale 1ns/10ps
module asbd_decoder
   import asbd_pkg::*;
#(
   parameter int NUM_SLAVES = 4,
   parameter int AW = 32,
   parameter bit DECODE_CYCLES = 1'b1, // [R26]
   parameter logic [NUM_SLAVES-1:0][AW-1:0] SLV_BASE = {
      32'h3000_0000, 32'h2000_0000, 32'h1000_0000, 32'h0000_0000},
   parameter logic [NUM_SLAVES-1:0][AW-1:0] SLV_MASK = {
      32'hF000_0000, 32'hF000_0000, 32'hF000_0000, 32'hF000_0000},
   parameter logic [NUM_SLAVES-1:0] SLV_PRIV_ONLY = 4'h0
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Master address and control, as seen on the bus
   input wire logic [1:0] btran_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [1:0] size_i,
   input wire logic [1:0] prot_i,
   // Resolved response lines, as seen on the bus
   input wire logic bwait_i,
   input wire logic blast_i,
   // Slave selects
   output logic [NUM_SLAVES-1:0] dsel_o,
   // Decoder's own response drive
   output logic rsp_wait_o,
   output logic rsp_last_o,
   output logic rsp_error_o,
   output logic rsp_oe_o
);

   // State
   asbd_state_e state_q;
   asbd_state_e state_d;
   logic [NUM_SLAVES-1:0] dsel_q;
   logic [NUM_SLAVES-1:0] dsel_d;

   // Captured address and control of the previous cycle
   logic [AW-1:0] addr_q;
   logic [AW-1:0] addr_d;
   logic [1:0] size_q;
   logic [1:0] size_d;
   logic [1:0] prot_q;
   logic [1:0] prot_d;

   // Address check
   logic use_live;
   logic [AW-1:0] chk_addr;
   logic [1:0] chk_size;
   logic [1:0] chk_prot;
   logic [NUM_SLAVES-1:0] hit;
   logic [NUM_SLAVES-1:0] allow;
   logic [NUM_SLAVES-1:0] sel_oh;
   logic found;
   logic aligned;
   logic access_ok;

   // Transfer start
   logic xfer_done;
   logic [1:0] next_type;

   asbd_resp_if rsp_if ();

   // Size legality against low address bits
   function automatic logic is_aligned(input logic [1:0] sz, input logic [1:0] lo);
      logic ok;
      ok = 1'b1;
      case (sz)
         ASBD_SIZE_BYTE: ok = 1'b1;
         ASBD_SIZE_HALF: ok = ((lo & ASBD_HALF_ALIGN_MASK) == 2'h0);
         ASBD_SIZE_WORD: ok = ((lo & ASBD_WORD_ALIGN_MASK) == 2'h0);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Capture every enabled cycle for the sequential path
   always_comb begin
      addr_d = addr_i;
      size_d = size_i;
      prot_d = prot_i;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_q <= '0;
         size_q <= ASBD_SIZE_BYTE;
         prot_q <= 2'h0;
      end else if (ce_i) begin
         addr_q <= addr_d;
         size_q <= size_d;
         prot_q <= prot_d;
      end
   end

   // Live address when decoding without decode cycles or at the end of one;
   // captured address for a sequential start, which avoids the long path
   always_comb begin
      use_live = !DECODE_CYCLES || (state_q == ASBD_ST_DECODE); // [R13]
      chk_addr = use_live ? addr_i : addr_q; // [R12]
      chk_size = use_live ? size_i : size_q;
      chk_prot = use_live ? prot_i : prot_q;
   end

   // One window check per slave
   genvar g;
   generate
      for (g = 0; g < NUM_SLAVES; g++) begin : g_region
         asbd_region_match #(
            .AW(AW)
         ) u_match (
            .addr_i(chk_addr),
            .prot_i(chk_prot),
            .base_i(SLV_BASE[g]),
            .mask_i(SLV_MASK[g]),
            .priv_only_i(SLV_PRIV_ONLY[g]),
            .hit_o(hit[g]),
            .allow_o(allow[g])
         );
      end
   endgenerate

   // Overlapping windows resolve to the lowest index
   always_comb begin
      sel_oh = '0;
      found = 1'b0;
      for (int i = 0; i < NUM_SLAVES; i++) begin
         if (hit[i] && !found) begin
            sel_oh[i] = 1'b1; // [R7]
            found = 1'b1;
         end
      end
      aligned = is_aligned(chk_size, chk_addr[1:0]);
      access_ok = found && ((sel_oh & allow) != '0) && aligned; // [R16]
   end

   // Transfer boundary and effective type of the next transfer
   always_comb begin
      xfer_done = !bwait_i; // [R15] [R18]
      next_type = btran_i;
      if (btran_i == ASBD_TRAN_SEQ && blast_i) begin
         next_type = ASBD_TRAN_NONSEQ; // [R17]
      end
   end

   // Cycle sequencing
   always_comb begin
      state_d = state_q;
      dsel_d = dsel_q;
      case (state_q)
         ASBD_ST_DECODE: begin
            // Selects appear as the decode cycle ends
            if (access_ok) begin
               state_d = ASBD_ST_SLAVE; // [R11]
               dsel_d = sel_oh;
            end else begin
               state_d = ASBD_ST_ERROR; // [R21]
               dsel_d = '0;
            end
         end
         ASBD_ST_ADDR_ONLY, ASBD_ST_SLAVE, ASBD_ST_ERROR: begin
            // Selects held until the running transfer completes
            if (xfer_done) begin // [R8]
               case (next_type) // [R23]
                  ASBD_TRAN_NONSEQ: begin
                     if (DECODE_CYCLES) begin // [R9]
                        state_d = ASBD_ST_DECODE; // [R10]
                        dsel_d = '0;
                     end else if (access_ok) begin
                        state_d = ASBD_ST_SLAVE; // [R13]
                        dsel_d = sel_oh;
                     end else begin
                        state_d = ASBD_ST_ERROR;
                        dsel_d = '0;
                     end
                  end
                  ASBD_TRAN_SEQ: begin
                     // No decode wait on a sequential transfer
                     if (access_ok) begin
                        state_d = ASBD_ST_SLAVE; // [R10]
                        dsel_d = sel_oh;
                     end else begin
                        state_d = ASBD_ST_ERROR;
                        dsel_d = '0;
                     end
                  end
                  default: begin
                     // Address ignored; reserved type acts as idle
                     state_d = ASBD_ST_ADDR_ONLY; // [R2]
                     dsel_d = '0; // [R7]
                  end
               endcase
            end
         end
         default: begin
            state_d = ASBD_ST_ADDR_ONLY;
            dsel_d = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ASBD_ST_ADDR_ONLY;
         dsel_q <= '0; // [R24]
      end else if (ce_i) begin
         state_q <= state_d;
         dsel_q <= dsel_d;
      end
   end

   // Decoder answers every cycle in which no slave is selected
   always_comb begin
      rsp_if.drive = 1'b1; // [R20]
      rsp_if.code = ASBD_RSP_DONE;
      case (state_d)
         ASBD_ST_ADDR_ONLY: rsp_if.code = ASBD_RSP_DONE; // [R21]
         ASBD_ST_DECODE: rsp_if.code = ASBD_RSP_WAIT; // [R10]
         ASBD_ST_ERROR: rsp_if.code = ASBD_RSP_ERROR; // [R16]
         ASBD_ST_SLAVE: rsp_if.drive = 1'b0; // [R14]
         default: rsp_if.code = ASBD_RSP_DONE;
      endcase
   end

   asbd_resp_gen u_resp (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .rsp(rsp_if)
   );

   // Outputs straight from flip-flops
   assign dsel_o = dsel_q;
   assign rsp_wait_o = rsp_if.rsp_wait; // [R19]
   assign rsp_last_o = rsp_if.rsp_last;
   assign rsp_error_o = rsp_if.rsp_error;
   assign rsp_oe_o = rsp_if.rsp_oe; // [R14]

endmodule

/* shared/asbd_pkg.sv */
// Constants, encodings and types of the system bus decoder
package asbd_pkg;

   // Transfer type field
   localparam logic [1:0] ASBD_TRAN_ADDR_ONLY = 2'h0;
   localparam logic [1:0] ASBD_TRAN_RSVD = 2'h1;
   localparam logic [1:0] ASBD_TRAN_NONSEQ = 2'h2;
   localparam logic [1:0] ASBD_TRAN_SEQ = 2'h3;

   // Transfer size field
   localparam logic [1:0] ASBD_SIZE_BYTE = 2'h0;
   localparam logic [1:0] ASBD_SIZE_HALF = 2'h1;
   localparam logic [1:0] ASBD_SIZE_WORD = 2'h2;
   localparam logic [1:0] ASBD_SIZE_RSVD = 2'h3;

   // Low address bits that must be zero per size
   localparam logic [1:0] ASBD_HALF_ALIGN_MASK = 2'h1;
   localparam logic [1:0] ASBD_WORD_ALIGN_MASK = 2'h3;

   // Protection field: bit 1 high marks a privileged access
   localparam int ASBD_PROT_PRIV_BIT = 1;

   // Response code {wait, last, error}
   localparam logic [2:0] ASBD_RSP_DONE = 3'h0;
   localparam logic [2:0] ASBD_RSP_ERROR = 3'h1;
   localparam logic [2:0] ASBD_RSP_LAST = 3'h2;
   localparam logic [2:0] ASBD_RSP_RETRACT = 3'h3;
   localparam logic [2:0] ASBD_RSP_WAIT = 3'h4;
   localparam logic [2:0] ASBD_RSP_RETNEXT = 3'h7;
   localparam int ASBD_RSP_WAIT_BIT = 2;
   localparam int ASBD_RSP_LAST_BIT = 1;
   localparam int ASBD_RSP_ERR_BIT = 0;

   // Response shown while in reset
   localparam logic [2:0] ASBD_RSP_RESET = ASBD_RSP_DONE;

   // Kind of the bus cycle now running
   typedef enum logic [1:0] {
      ASBD_ST_ADDR_ONLY,
      ASBD_ST_DECODE,
      ASBD_ST_SLAVE,
      ASBD_ST_ERROR
   } asbd_state_e;

endpackage

/* shared/asbd_resp_if.sv */
// Response request and registered response lines between decoder parts
`timescale 1ns/10ps
interface asbd_resp_if;
   logic [2:0] code;
   logic drive;
   logic rsp_wait;
   logic rsp_last;
   logic rsp_error;
   logic rsp_oe;

   modport src (
      output code,
      output drive,
      input rsp_wait,
      input rsp_last,
      input rsp_error,
      input rsp_oe
   );

   modport gen (
      input code,
      input drive,
      output rsp_wait,
      output rsp_last,
      output rsp_error,
      output rsp_oe
   );
endinterface

/* logic/asbd_region_match.sv */
// One slave address window with its privilege check
`timescale 1ns/10ps
module asbd_region_match
   import asbd_pkg::*;
#(
   parameter int AW = 32
) (
   // Address and protection under test
   input wire logic [AW-1:0] addr_i,
   input wire logic [1:0] prot_i,
   // Window description
   input wire logic [AW-1:0] base_i,
   input wire logic [AW-1:0] mask_i,
   input wire logic priv_only_i,
   // Results
   output logic hit_o,
   output logic allow_o
);

   always_comb begin
      hit_o = ((addr_i & mask_i) == (base_i & mask_i));
      allow_o = !priv_only_i || prot_i[ASBD_PROT_PRIV_BIT];
   end

endmodule

/* logic/asbd_resp_gen.sv */
// Registered drive of the decoder's own transfer response
`timescale 1ns/10ps
module asbd_resp_gen
   import asbd_pkg::*;
(
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Request in, registered lines out
   asbd_resp_if.gen rsp
);

   logic [2:0] code_q;
   logic [2:0] code_d;
   logic oe_q;
   logic oe_d;

   // Reserved codes never leave this block
   always_comb begin
      code_d = rsp.code;
      oe_d = rsp.drive;
      if (!rsp.drive) begin
         code_d = ASBD_RSP_DONE;
      end
      if (code_d[ASBD_RSP_WAIT_BIT] && (code_d[ASBD_RSP_LAST_BIT] != code_d[ASBD_RSP_ERR_BIT])) begin // [R19]
         code_d = ASBD_RSP_ERROR;
      end
   end

   // Decoder answers in reset since no slave is selected
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         code_q <= ASBD_RSP_RESET;
         oe_q <= 1'b1;
      end else if (ce_i) begin
         code_q <= code_d;
         oe_q <= oe_d;
      end
   end

   assign rsp.rsp_wait = code_q[ASBD_RSP_WAIT_BIT];
   assign rsp.rsp_last = code_q[ASBD_RSP_LAST_BIT];
   assign rsp.rsp_error = code_q[ASBD_RSP_ERR_BIT];
   assign rsp.rsp_oe = oe_q;

endmodule

/* sim/asbd_slave_model.sv */
// Behavioural bus slave: waits, then answers with a planned final code
`timescale 1ns/10ps
module asbd_slave_model
   import asbd_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Select and response plan
   input wire logic sel_i,
   input wire logic [1:0] wait_n_i,
   input wire logic [2:0] fin_i,
   // Response
   output logic [2:0] rsp_o,
   output logic oe_o
);
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   always_comb begin
      cnt_d = (sel_i && rsp_o[ASBD_RSP_WAIT_BIT]) ? cnt_q + 3'h1 : 3'h0;
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) cnt_q <= 3'h0;
      else cnt_q <= cnt_d;
   end
   always_comb begin
      if (cnt_q < {1'b0, wait_n_i}) rsp_o = ASBD_RSP_WAIT;
      else if (fin_i == ASBD_RSP_RETRACT && cnt_q == {1'b0, wait_n_i}) begin
         rsp_o = ASBD_RSP_RETNEXT;
      end
      else rsp_o = fin_i;
   end
   // Floats whenever unselected or in reset
   assign oe_o = sel_i && !rst_i;
endmodule

/* sim/asbd_decoder_chk.sv */
// Port-level assertions of the system bus decoder
`timescale 1ns/10ps
module asbd_decoder_chk
   import asbd_pkg::*;
#(
   parameter int NUM_SLAVES = 4,
   parameter bit DECODE_CYCLES = 1'b1
) (
   // Clock, reset, enable, bus inputs
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [1:0] btran_i,
   input wire logic bwait_i,
   input wire logic blast_i,
   // Decoder outputs
   input wire logic [NUM_SLAVES-1:0] dsel_o,
   input wire logic rsp_wait_o,
   input wire logic rsp_last_o,
   input wire logic rsp_error_o,
   input wire logic rsp_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] code;
   assign code = {rsp_wait_o, rsp_last_o, rsp_error_o};
   sequence s_take(logic [1:0] t); ce_i && !bwait_i && btran_i == t; endsequence
   sequence s_seq_nb; ce_i && !bwait_i && !blast_i && btran_i == ASBD_TRAN_SEQ; endsequence
   sequence s_decode; rsp_oe_o && code == ASBD_RSP_WAIT && dsel_o == '0; endsequence
   sequence s_result; dsel_o != '0 || code == ASBD_RSP_ERROR; endsequence
   property p_onehot; $onehot0(dsel_o); endproperty
   property p_owner; rsp_oe_o == (dsel_o == '0); endproperty
   property p_rsvd; rsp_oe_o |-> code != 3'h5 && code != 3'h6; endproperty
   property p_hold; ce_i && bwait_i && dsel_o != '0 |=> $stable(dsel_o); endproperty
   property p_idle;
      ce_i && !bwait_i && !btran_i[1] |=> rsp_oe_o && code == ASBD_RSP_DONE;
   endproperty
   property p_nseq;
      s_take(ASBD_TRAN_NONSEQ) |=> if (DECODE_CYCLES) s_decode ##1 s_result else s_result;
   endproperty
   property p_seq; s_seq_nb |=> s_result; endproperty
   property p_blast;
      ce_i && !bwait_i && blast_i && btran_i == ASBD_TRAN_SEQ
         |=> if (DECODE_CYCLES) s_decode else s_result;
   endproperty
   property p_one_wait; rsp_oe_o && rsp_wait_o |=> !(rsp_oe_o && rsp_wait_o); endproperty
   property p_exit; $fell(rst_i) |-> dsel_o == '0 && rsp_oe_o; endproperty
   a_onehot: assert property (p_onehot) else $error("two selects active");
   a_owner: assert property (p_owner) else $error("response owner wrong");
   a_rsvd: assert property (p_rsvd) else $error("reserved response code");
   a_hold: assert property (p_hold) else $error("select moved while waited");
   a_idle: assert property (p_idle) else $error("idle cycle not done");
   a_nseq: assert property (p_nseq) else $error("nonseq timing wrong");
   a_seq: assert property (p_seq) else $error("seq got a wait");
   a_blast: assert property (p_blast) else $error("seq after last not decoded");
   a_one_wait: assert property (p_one_wait) else $error("decoder waited twice");
   a_exit: assert property (p_exit) else $error("reset state wrong");
endmodule
bind asbd_decoder asbd_decoder_chk #(
   .NUM_SLAVES(NUM_SLAVES),
   .DECODE_CYCLES(DECODE_CYCLES)
) u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .btran_i(btran_i),
   .bwait_i(bwait_i), .blast_i(blast_i), .dsel_o(dsel_o), .rsp_wait_o(rsp_wait_o),
   .rsp_last_o(rsp_last_o), .rsp_error_o(rsp_error_o), .rsp_oe_o(rsp_oe_o)
);

/* sim/asbd_decoder_tb.sv */
// Self-checking testbench of the system bus decoder, two builds each with one slave model
`timescale 1ns/10ps
module asbd_decoder_tb
   import asbd_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] btran = ASBD_TRAN_ADDR_ONLY;
   logic [31:0] addr = 32'h0;
   logic [1:0] size = ASBD_SIZE_WORD;
   logic [1:0] prot = 2'h0;
   logic [1:0] wn = 2'h0;
   logic [2:0] fin = ASBD_RSP_DONE;
   logic [3:0] dsel;
   logic rw, rl, re, roe, soe, prevdone;
   logic [2:0] srsp, bus;
   logic [4:0] q[$];
   logic [2:0] fins[4] = '{ASBD_RSP_DONE, ASBD_RSP_LAST, ASBD_RSP_ERROR, ASBD_RSP_RETRACT};
   int n_fail = 0;
   int checks_done = 0;
   // Slave 3 window only takes privileged accesses
   localparam logic [3:0] PRIV_MAP = 4'h8;
   logic [3:0] dsel_nd;
   logic rw_nd, rl_nd, re_nd, roe_nd, soe_nd;
   logic [2:0] srsp_nd, bus_nd;
   asbd_decoder #(.SLV_PRIV_ONLY(PRIV_MAP)) dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
      .btran_i(btran), .addr_i(addr), .size_i(size), .prot_i(prot), .bwait_i(bus[2]),
      .blast_i(bus[1]), .dsel_o(dsel), .rsp_wait_o(rw), .rsp_last_o(rl), .rsp_error_o(re),
      .rsp_oe_o(roe));
   asbd_slave_model u_slv (.sys_clk_i(clk), .rst_i(rst), .sel_i(|dsel), .wait_n_i(wn),
      .fin_i(fin), .rsp_o(srsp), .oe_o(soe));
   // Undriven lines show a wrong pattern rather than a friendly level
   assign bus = roe ? {rw, rl, re} : (soe ? srsp : 3'h5);
   // Same stimulus into a build without decode cycles; its bound checker judges it
   asbd_decoder #(.DECODE_CYCLES(1'b0)) dut_nd (.sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1),
      .btran_i(btran), .addr_i(addr), .size_i(size), .prot_i(prot), .bwait_i(bus_nd[2]),
      .blast_i(bus_nd[1]), .dsel_o(dsel_nd), .rsp_wait_o(rw_nd), .rsp_last_o(rl_nd),
      .rsp_error_o(re_nd), .rsp_oe_o(roe_nd));
   asbd_slave_model u_slv_nd (.sys_clk_i(clk), .rst_i(rst), .sel_i(|dsel_nd), .wait_n_i(wn),
      .fin_i(fin), .rsp_o(srsp_nd), .oe_o(soe_nd));
   assign bus_nd = roe_nd ? {rw_nd, rl_nd, re_nd} : (soe_nd ? srsp_nd : 3'h5);
   initial forever #10 clk = ~clk;
   function automatic logic [4:0] expect_of(input logic [31:0] a, input logic [1:0] sz,
      input logic [1:0] p);
      logic bad;
      bad = a[31:30] != 2'h0 || sz == ASBD_SIZE_RSVD;
      bad = bad || (PRIV_MAP[a[29:28]] && !p[ASBD_PROT_PRIV_BIT]);
      if (sz == ASBD_SIZE_HALF) bad = bad || (a[1:0] & ASBD_HALF_ALIGN_MASK) != 2'h0;
      if (sz == ASBD_SIZE_WORD) bad = bad || (a[1:0] & ASBD_WORD_ALIGN_MASK) != 2'h0;
      return bad ? 5'h10 : {1'b0, 4'h1 << a[29:28]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   // Holds the request until an edge with wait low takes it
   task automatic issue(input logic [1:0] t, input logic [31:0] a, input logic [1:0] sz);
      int k;
      k = 0;
      btran <= t;
      addr <= a;
      size <= sz;
      @(negedge clk);
      while (bus[2] !== 1'b0 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk("wait bound", 8'h0, 8'(k / 50));
      @(posedge clk);
   endtask
   // Leading idle carries the address and lets the slave plan change safely
   task automatic xfer(input logic [1:0] t, input logic [31:0] a, input logic [1:0] sz);
      logic [1:0] p;
      // Privilege fixed for the whole transfer so the expectation can use it
      p = 2'($urandom);
      prot <= p;
      wn <= 2'($urandom % 3);
      fin <= fins[$urandom % 4];
      issue(ASBD_TRAN_ADDR_ONLY, a, sz);
      issue(t, a, sz);
      if (t[1]) q.push_back(expect_of(a, sz, p));
      issue(ASBD_TRAN_ADDR_ONLY, a, sz);
   endtask
   always @(posedge clk) begin
      if (!rst && prevdone && (|dsel || (roe && {rw, rl, re} == ASBD_RSP_ERROR))) begin
         chk("select", (q.size() != 0) ? 8'(q[0]) : 8'hFF, {3'h0, roe & re, dsel});
         if (q.size() != 0) void'(q.pop_front());
      end
      prevdone <= !bus[2] || (roe && rw);
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      $display("Watchdog expired");
      end_of_test();
   end
   initial begin
      void'($urandom(32'h09E9));
      repeat (2) @(negedge clk);
      chk("reset state", 8'h10, {3'h0, roe, dsel});
      @(posedge clk);
      rst <= 1'b0;
      for (int s = 0; s < 4; s++) xfer(ASBD_TRAN_NONSEQ, {4'(s), 28'h0}, ASBD_SIZE_WORD);
      $display("test nonseq done");
      xfer(ASBD_TRAN_NONSEQ, 32'h4000_0000, ASBD_SIZE_WORD);
      xfer(ASBD_TRAN_NONSEQ, 32'h1000_0001, ASBD_SIZE_HALF);
      xfer(ASBD_TRAN_NONSEQ, 32'h2000_0002, ASBD_SIZE_WORD);
      xfer(ASBD_TRAN_SEQ, 32'h0000_0000, ASBD_SIZE_RSVD);
      $display("test refusals done");
      for (int s = 0; s < 4; s++) xfer(ASBD_TRAN_SEQ, {4'(s), 28'h40}, ASBD_SIZE_HALF);
      xfer(ASBD_TRAN_RSVD, 32'h1000_0000, ASBD_SIZE_WORD);
      $display("test seq and reserved done");
      for (int f = 0; f < 2; f++) begin
         fin <= fins[f];
         prot <= 2'h2;
         issue(ASBD_TRAN_ADDR_ONLY, 32'h3000_0000, ASBD_SIZE_WORD);
         issue(ASBD_TRAN_NONSEQ, 32'h3000_0000, ASBD_SIZE_WORD);
         q.push_back(5'h08);
         issue(ASBD_TRAN_SEQ, 32'h3000_0004, ASBD_SIZE_WORD);
         q.push_back(5'h08);
         issue(ASBD_TRAN_ADDR_ONLY, 32'h3000_0004, ASBD_SIZE_WORD);
      end
      $display("test burst done");
      repeat (40) xfer({1'b1, 1'($urandom)}, $urandom & 32'h7FFF_FFFF, 2'($urandom));
      $display("test random done");
      rst <= 1'b1;
      @(negedge clk);
      chk("second reset", 8'h10, {3'h0, roe, dsel});
      @(posedge clk);
      rst <= 1'b0;
      xfer(ASBD_TRAN_NONSEQ, 32'h2000_0000, ASBD_SIZE_BYTE);
      repeat (4) @(posedge clk);
      chk("pending results", 8'h0, 8'(q.size()));
      $display("test reset done");
      end_of_test();
   end
endmodule
